// file: common/tsx_defs.svh
// Purpose: Constants of the timeslot cross-connect switch
// Assumes: One board, four lines, 32 slots per frame
// Notes:   Counts, opcodes, slot mask and fill/reset values; types live in tsx_pkg
`ifndef TSX_DEFS_SVH
`define TSX_DEFS_SVH

`define TSX_LINES       4
`define TSX_CHANNELS    128
`define TSX_SLOTS       32
`define TSX_FIFO_DEPTH  16
`define TSX_OP_DRIVE    2'h0
`define TSX_OP_LISTEN   2'h1
`define TSX_OP_XCON     2'h2
`define TSX_T1_SLOTS    32'h00ffffff
`define TSX_IDLE_BYTE   8'hff
`define TSX_BASE_RST    7'h00

`endif

// file: common/tsx_pkg.sv
// Purpose: Types shared by the cross-connect modules
// Assumes: Field widths sized for four lines and 128 channels
// Notes:   Command word is carried whole through the command FIFO
package tsx_pkg;

  // One host command; unused fields are ignored per opcode
  typedef struct packed {
    logic [1:0]  op;
    logic [1:0]  board;
    logic [1:0]  line;
    logic [1:0]  aux_line;
    logic [4:0]  slot;
    logic [6:0]  channel;
    logic        e1;
    logic [31:0] mask;
  } cmd_s;

  typedef enum logic {st_fetch, st_apply} exec_state_e;

endpackage : tsx_pkg

// file: common/fifo_if.sv
// Purpose: Valid/ready word carrier between internal modules
// Assumes: Single clock domain
// Notes:   src drives valid and data, sink drives ready
interface fifo_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : fifo_if

// file: rtl/cmd_fifo.sv
// Purpose: Command FIFO between host port and executor
// Assumes: Write and read on the same clock
// Notes:   in_ready and out.valid come straight from flip-flops
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  fifo_if.src                   out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, rd_q;
  logic [AW:0]      cnt_q;
  logic             not_full_q, not_empty_q;
  wire              push = in_valid && not_full_q;
  wire              pop  = out.ready && not_empty_q;
  wire [AW:0]       cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign in_ready  = not_full_q;
  assign out.valid = not_empty_q;
  assign out.data  = mem_q[rd_q];

  // Storage array, no reset needed
  always_ff @(posedge clock) begin
    if (push) mem_q[wr_q] <= in_data;
  end

  // Pointers and registered flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q        <= '0;
      rd_q        <= '0;
      cnt_q       <= '0;
      not_full_q  <= 1'b1;
      not_empty_q <= 1'b0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q       <= cnt_d;
      not_full_q  <= cnt_d != DEPTH[AW:0];
      not_empty_q <= cnt_d != '0;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clock) disable iff (!rst_n)
    cnt_q == DEPTH[AW:0] |-> !in_ready)
    else $error("fifo accepts while full");

endmodule : cmd_fifo

// file: rtl/timeslot_cross_connect.sv
// Purpose: Timeslot cross-connect between line units and switch channels
// Assumes: Slot strobes come from framer logic on the same clock
// Notes:   Board index is a strap pin, synchronised before use
// Operation
// - Drive target is board plus one line
// - Selected slots take consecutive channels from base
// - Only mask-selected slots reach the switch
// - E1 mask fffefffe selects thirty voice slots
// - T1 mask 00fffffe selects slots one to 23
// - Channel numbering is local to each board
// - Listen connects line slot to switch channel
// - Cross-connect any two lines on board
// - Stream command maps slot group line to line
// - Static drives stay fixed once set up
`include "tsx_defs.svh"

module timeslot_cross_connect #(
  parameter int NL  = `TSX_LINES,
  parameter int NCH = `TSX_CHANNELS
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic [1:0]          board_index_pin,
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire tsx_pkg::cmd_s       cmd_data,
  input  wire logic                slot_strobe,
  input  wire logic [4:0]          slot_index,
  input  wire logic [NL-1:0][7:0]  line_rx_data,
  output logic [NL-1:0][7:0]       line_tx_data,
  output logic                     tx_valid,
  output logic                     cmd_done,
  output logic                     cmd_error,
  output logic [NL-1:0]            drive_locked
);
  import tsx_pkg::*;

  // Count of set mask bits below a slot
  function automatic logic [5:0] ones_below(input logic [31:0] m, input logic [4:0] s);
    logic [5:0] n;
    n = '0;
    for (int i = 0; i < 32; i++) begin
      if (i < s && m[i]) n = n + 6'h01;
    end
    return n;
  endfunction : ones_below

  // Line index check against the fitted line count
  function automatic logic line_ok(input logic [1:0] l);
    return {30'h0, l} < NL;
  endfunction : line_ok

  // Strap synchroniser
  logic [1:0] brd_meta_q, brd_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      brd_meta_q <= 2'h0;
      brd_q      <= 2'h0;
    end else begin
      brd_meta_q <= board_index_pin;
      brd_q      <= brd_meta_q;
    end
  end

  // Command queue; drained only outside slot strobes
  fifo_if #(.WIDTH($bits(cmd_s))) cq ();
  cmd_fifo #(.WIDTH($bits(cmd_s)), .DEPTH(`TSX_FIFO_DEPTH)) u_fifo (
    .clock    (clock),
    .rst_n    (rst_n),
    .in_valid (cmd_valid),
    .in_ready (cmd_ready),
    .in_data  (cmd_data),
    .out      (cq.src)
  );

  // Executor state and the command word being applied
  exec_state_e st_q;
  cmd_s        cmd_q;
  assign cq.ready = (st_q == st_fetch) && !slot_strobe;
  wire take = cq.valid && cq.ready;

  // Static drive settings and listen/stream maps
  logic [6:0]  base_q      [NL];
  logic [31:0] mask_q      [NL];
  logic [NL-1:0] e1_q, drive_set_q;
  logic [31:0] lmap_v_q    [NL];
  logic [6:0]  lmap_ch_q   [NL][32];
  logic [31:0] xmap_v_q    [NL];
  logic [1:0]  xmap_src_q  [NL][32];
  logic [7:0]  sw_mem_q    [NCH];
  // Output registers
  logic [NL-1:0][7:0] tx_q;
  logic        tx_valid_q, done_q, err_q;

  // Command decode
  wire apply     = st_q == st_apply;
  wire own_board = cmd_q.board == brd_q;
  wire do_drive  = apply && cmd_q.op == `TSX_OP_DRIVE && own_board
                   && line_ok(cmd_q.line) && !drive_set_q[cmd_q.line];
  wire do_listen = apply && cmd_q.op == `TSX_OP_LISTEN && own_board
                   && line_ok(cmd_q.line) && {25'h0, cmd_q.channel} < NCH;
  wire do_xcon   = apply && cmd_q.op == `TSX_OP_XCON && own_board
                   && line_ok(cmd_q.line) && line_ok(cmd_q.aux_line);
  wire do_any    = do_drive || do_listen || do_xcon;
  // Anything not applied is still answered, with an error
  wire bad_cmd   = apply && !do_any;

  // Per-line slot path
  logic [NL-1:0]      wr_en;
  logic [NL-1:0][6:0] wr_ch;
  logic [NL-1:0][7:0] tx_d;
  genvar gl;
  generate
    for (gl = 0; gl < NL; gl++) begin : g_line
      // T1 lines see only 24 slots; E1 lines see all 32
      wire [31:0] eff_mask = e1_q[gl] ? mask_q[gl]
                                      : (mask_q[gl] & `TSX_T1_SLOTS);
      wire [7:0]  ch_sum   = {1'b0, base_q[gl]} + {2'h0, ones_below(eff_mask, slot_index)};
      wire        ch_fit   = {24'h0, ch_sum} < NCH;
      assign wr_ch[gl] = ch_sum[6:0];
      assign wr_en[gl] = slot_strobe && drive_set_q[gl]
                         && eff_mask[slot_index] && ch_fit;
      // Listen wins over stream on a shared slot
      wire        lv  = lmap_v_q[gl][slot_index];
      wire        xv  = xmap_v_q[gl][slot_index];
      wire [6:0]  lch = lmap_ch_q[gl][slot_index];
      wire [1:0]  xs  = xmap_src_q[gl][slot_index];
      assign tx_d[gl] = lv ? sw_mem_q[lch]
                      : xv ? line_rx_data[xs]
                      : `TSX_IDLE_BYTE;
    end
  endgenerate

  // Switch channel memory, written by driven slots
  always_ff @(posedge clock) begin
    for (int l = 0; l < NL; l++) begin
      if (wr_en[l]) sw_mem_q[wr_ch[l]] <= line_rx_data[l];
    end
  end

  // Executor state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= st_fetch;
      cmd_q <= '0;
    end else begin
      case (st_q)
        st_fetch: begin
          if (take) begin
            cmd_q <= cq.data;
            st_q  <= st_apply;
          end
        end
        st_apply: st_q <= st_fetch;
        default:  st_q <= st_fetch;
      endcase
    end
  end

  // Static drive table; each line may be set once only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int l = 0; l < NL; l++) begin
        base_q[l] <= `TSX_BASE_RST;
        mask_q[l] <= 32'h00000000;
      end
      e1_q        <= '0;
      drive_set_q <= '0;
    end else if (do_drive) begin
      base_q[cmd_q.line]      <= cmd_q.channel;
      mask_q[cmd_q.line]      <= cmd_q.mask;
      e1_q[cmd_q.line]        <= cmd_q.e1;
      drive_set_q[cmd_q.line] <= 1'b1;
    end
  end

  // Listen and stream maps; latest command owns the slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int l = 0; l < NL; l++) begin
        lmap_v_q[l] <= 32'h00000000;
        xmap_v_q[l] <= 32'h00000000;
        for (int s = 0; s < 32; s++) begin
          lmap_ch_q[l][s]  <= 7'h00;
          xmap_src_q[l][s] <= 2'h0;
        end
      end
    end else if (do_listen) begin
      lmap_v_q[cmd_q.line][cmd_q.slot]  <= 1'b1;
      lmap_ch_q[cmd_q.line][cmd_q.slot] <= cmd_q.channel;
      xmap_v_q[cmd_q.line][cmd_q.slot]  <= 1'b0;
    end else if (do_xcon) begin
      for (int s = 0; s < 32; s++) begin
        if (cmd_q.mask[s]) begin
          xmap_v_q[cmd_q.aux_line][s]   <= 1'b1;
          xmap_src_q[cmd_q.aux_line][s] <= cmd_q.line;
          lmap_v_q[cmd_q.aux_line][s]   <= 1'b0;
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_q       <= {NL{`TSX_IDLE_BYTE}};
      tx_valid_q <= 1'b0;
      done_q     <= 1'b0;
      err_q      <= 1'b0;
    end else begin
      if (slot_strobe) tx_q <= tx_d;
      tx_valid_q <= slot_strobe;
      done_q     <= do_any;
      err_q      <= bad_cmd;
    end
  end

  // Top outputs straight from flops
  assign line_tx_data = tx_q;
  assign tx_valid     = tx_valid_q;
  assign cmd_done     = done_q;
  assign cmd_error    = err_q;
  assign drive_locked = drive_set_q;

  // Refusals: foreign board and a second drive on a locked line
  a_board_match_only: assert property (@(posedge clock) disable iff (!rst_n)
    apply && !own_board |=> cmd_error && !cmd_done)
    else $error("foreign board command not refused");

  a_foreign_no_lock: assert property (@(posedge clock) disable iff (!rst_n)
    apply && !own_board |=> $stable(drive_set_q))
    else $error("foreign board command changed a drive");

  a_drive_relock_refused: assert property (@(posedge clock) disable iff (!rst_n)
    apply && cmd_q.op == `TSX_OP_DRIVE && drive_set_q[cmd_q.line] |=> cmd_error && !cmd_done)
    else $error("second drive on a locked line not refused");

  // Drive path: base channel, mask gating, slot limits
  a_drive_first_slot: assert property (@(posedge clock) disable iff (!rst_n)
    wr_en[0] && (mask_q[0] & ((32'h1 << slot_index) - 32'h1)) == 32'h0
    |-> wr_ch[0] == base_q[0])
    else $error("first voice slot not on base channel");

  a_mask_gates_drive: assert property (@(posedge clock) disable iff (!rst_n)
    wr_en[0] |-> mask_q[0][slot_index] && drive_set_q[0])
    else $error("unmasked slot driven");

  a_e1_upper_slots: assert property (@(posedge clock) disable iff (!rst_n)
    slot_strobe && drive_set_q[0] && e1_q[0] && mask_q[0][slot_index] && g_line[0].ch_fit
    |-> wr_en[0])
    else $error("e1 voice slot not driven");

  a_t1_slot_limit: assert property (@(posedge clock) disable iff (!rst_n)
    wr_en[1] && !e1_q[1] |-> slot_index < 5'd24)
    else $error("t1 slot beyond 23 driven");

  a_t1_channel_span: assert property (@(posedge clock) disable iff (!rst_n)
    wr_en[1] && !e1_q[1] |-> wr_ch[1] < base_q[1] + 7'd23)
    else $error("t1 line uses more than 23 channels");

  a_channel_no_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    wr_en[2] |-> wr_ch[2] >= base_q[2])
    else $error("switch channel wrapped below base");

  a_drive_stays_set: assert property (@(posedge clock) disable iff (!rst_n)
    drive_set_q[0] |=> drive_set_q[0] && $stable(base_q[0]) && $stable(mask_q[0]))
    else $error("static drive changed");

  // Listen and stream maps; unwritten channels compare unknown to unknown
  a_listen_stored: assert property (@(posedge clock) disable iff (!rst_n)
    do_listen |=> lmap_v_q[$past(cmd_q.line)][$past(cmd_q.slot)]
                  && lmap_ch_q[$past(cmd_q.line)][$past(cmd_q.slot)] == $past(cmd_q.channel))
    else $error("listen not stored");

  a_listen_clears_stream: assert property (@(posedge clock) disable iff (!rst_n)
    do_listen |=> !xmap_v_q[$past(cmd_q.line)][$past(cmd_q.slot)])
    else $error("listen left a stream on its slot");

  a_xcon_pair_map: assert property (@(posedge clock) disable iff (!rst_n)
    do_xcon && cmd_q.mask[8]
    |=> xmap_v_q[$past(cmd_q.aux_line)][8] && !lmap_v_q[$past(cmd_q.aux_line)][8]
        && xmap_src_q[$past(cmd_q.aux_line)][8] == $past(cmd_q.line))
    else $error("stream command did not map slot eight");

  a_listen_output: assert property (@(posedge clock) disable iff (!rst_n)
    slot_strobe && lmap_v_q[0][slot_index]
    |=> tx_valid && line_tx_data[0] === $past(sw_mem_q[lmap_ch_q[0][slot_index]]))
    else $error("listen slot carries wrong channel");

  a_xcon_output: assert property (@(posedge clock) disable iff (!rst_n)
    slot_strobe && xmap_v_q[2][slot_index] && !lmap_v_q[2][slot_index]
    |=> line_tx_data[2] == $past(line_rx_data[xmap_src_q[2][slot_index]]))
    else $error("stream slot not copied from source line");

  a_idle_fill: assert property (@(posedge clock) disable iff (!rst_n)
    slot_strobe && !lmap_v_q[0][slot_index] && !xmap_v_q[0][slot_index]
    |=> line_tx_data[0] == `TSX_IDLE_BYTE)
    else $error("unconnected slot not idle");

endmodule : timeslot_cross_connect

// file: sim/host_model.sv
// Purpose: Host side model that offers switch commands and counts answers
// Assumes: One command offered at a time on the valid/ready port
// Notes:   Released command bus shows the inverse of its last word
module host_model (
  input  wire logic          clock,
  input  wire logic          cmd_ready,
  input  wire logic          cmd_done,
  input  wire logic          cmd_error,
  output logic               cmd_valid,
  output tsx_pkg::cmd_s      cmd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import tsx_pkg::*;
  int n_done = 0;
  int n_err  = 0;
  int hangs  = 0;

  initial begin
    cmd_valid = 1'b0;
    cmd_data  = '0;
  end

  // Answer counters
  always @(posedge clock) begin
    if (cmd_done === 1'b1) n_done++;
    if (cmd_error === 1'b1) n_err++;
  end

  // Offer one word, hold it until taken
  task automatic push(input cmd_s c);
    cmd_s w;
    int   k;
    w = c;
    if (w.op == 2'h0) w.mask[0] = 1'b0;
    @(posedge clock);
    cmd_data  <= w;
    cmd_valid <= 1'b1;
    k = 0;
    @(negedge clock);
    while (cmd_ready !== 1'b1 && k < 200) begin
      @(negedge clock);
      k++;
    end
    if (k == 200) hangs++;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_data  <= ~w;
  endtask : push
endmodule : host_model

// file: sim/timeslot_cross_connect_bench.sv
// Purpose: Self-checking bench of the timeslot cross-connect
// Assumes: Board strap 0, four lines, 128 channels
// Notes:   Switch memory model skips channels never written
module timeslot_cross_connect_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tsx_pkg::*;
  logic            clock = 1'b0;
  logic            rst_n = 1'b0;
  logic            cmd_valid;
  logic            cmd_ready;
  cmd_s            cmd_data;
  logic            slot_strobe = 1'b0;
  logic [4:0]      slot_index = 5'h00;
  logic [3:0][7:0] line_rx_data = '0;
  logic [3:0][7:0] line_tx_data;
  logic            tx_valid;
  logic            cmd_done;
  logic            cmd_error;
  logic [3:0]      drive_locked;
  int              mismatches = 0;
  int              checks_done = 0;
  logic [7:0]      mem[128];
  bit              memv[128];
  bit              drv_on[4];
  logic [31:0]     drv_mask[4];
  bit              drv_e1[4];
  int              drv_base[4];
  int              lis_ch[4][32];
  int              str_src[4][32];

  always #12.5 clock = ~clock;

  timeslot_cross_connect #(.NL(4), .NCH(128)) timeslot_cross_connect_inst (
    .clock(clock), .rst_n(rst_n), .board_index_pin(2'h0), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .slot_strobe(slot_strobe),
    .slot_index(slot_index), .line_rx_data(line_rx_data), .line_tx_data(line_tx_data),
    .tx_valid(tx_valid), .cmd_done(cmd_done), .cmd_error(cmd_error),
    .drive_locked(drive_locked));

  host_model host_model_inst (
    .clock(clock), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data));

  // Command word builder
  function automatic cmd_s mk(logic [1:0] op, logic [1:0] bd, logic [1:0] ln, logic [1:0] ax,
                              logic [4:0] sl, logic [6:0] ch, logic e1, logic [31:0] m);
    cmd_s c;
    c = '{op, bd, ln, ax, sl, ch, e1, m};
    return c;
  endfunction : mk

  // Switch channel written by a line slot, -1 if none
  function automatic int chan_of(int l, int s);
    logic [31:0] m;
    int          c;
    m = drv_e1[l] ? drv_mask[l] : drv_mask[l] & 32'h00ffffff;
    if (!drv_on[l] || m[s] !== 1'b1) return -1;
    c = drv_base[l];
    for (int b = 0; b < s; b++) c += int'(m[b]);
    return (c < 128) ? c : -1;
  endfunction : chan_of

  task automatic chk_bits(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_bits

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // One command, answer checked and model updated
  task automatic send(input cmd_s c);
    int d0;
    int e0;
    int k;
    bit err;
    d0 = host_model_inst.n_done;
    e0 = host_model_inst.n_err;
    err = (c.board != 2'h0) || (c.op == 2'h3) || (c.op == 2'h0 && drv_on[c.line]);
    host_model_inst.push(c);
    k = 0;
    while (host_model_inst.n_done == d0 && host_model_inst.n_err == e0 && k < 100) begin
      @(negedge clock);
      k++;
    end
    if (k == 100) begin
      mismatches++;
      results();
    end
    chk_bits("cmd_error count", 32'(e0 + int'(err)), 32'(host_model_inst.n_err));
    if (!err) begin
      case (c.op)
        2'h0: begin
          drv_on[c.line]   = 1'b1;
          drv_mask[c.line] = c.mask;
          drv_e1[c.line]   = c.e1;
          drv_base[c.line] = int'(c.channel);
        end
        2'h1: begin
          lis_ch[c.line][c.slot]  = int'(c.channel);
          str_src[c.line][c.slot] = -1;
        end
        default: begin
          for (int s = 0; s < 32; s++) begin
            if (c.mask[s]) begin
              str_src[c.aux_line][s] = int'(c.line);
              lis_ch[c.aux_line][s]  = -1;
            end
          end
        end
      endcase
    end
  endtask : send

  // One timeslot strobe with random line bytes
  task automatic slot(input int s);
    logic [3:0][7:0] rx;
    int              ch;
    for (int l = 0; l < 4; l++) rx[l] = 8'($urandom);
    @(posedge clock);
    slot_strobe  <= 1'b1;
    slot_index   <= 5'(s);
    line_rx_data <= rx;
    @(posedge clock);
    slot_strobe <= 1'b0;
    #1;
    chk_bits("tx_valid", 32'h1, {31'h0, tx_valid});
    for (int l = 0; l < 4; l++) begin
      ch = lis_ch[l][s];
      if (ch >= 0) begin
        if (memv[ch]) chk_byte("listen byte", mem[ch], line_tx_data[l]);
      end else if (str_src[l][s] >= 0) begin
        chk_byte("stream byte", rx[str_src[l][s]], line_tx_data[l]);
      end else begin
        chk_byte("idle byte", 8'hff, line_tx_data[l]);
      end
    end
    for (int l = 0; l < 4; l++) begin
      ch = chan_of(l, s);
      if (ch >= 0) begin
        mem[ch]  = rx[l];
        memv[ch] = 1'b1;
      end
    end
  endtask : slot

  // Main sequence
  initial begin
    int d0;
    for (int l = 0; l < 4; l++) begin
      for (int s = 0; s < 32; s++) begin
        lis_ch[l][s]  = -1;
        str_src[l][s] = -1;
      end
    end
    void'($urandom(35));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk_bits("reset tx", 32'hffffffff, line_tx_data);
    chk_bits("reset locks", 32'h0, {28'h0, drive_locked});
    $display("test reset done");
    d0 = host_model_inst.n_done;
    @(posedge clock);
    slot_strobe <= 1'b1;
    fork
      for (int i = 0; i < 17; i++) host_model_inst.push(mk(1, 0, 2, 0, 5'(i), 7'(30 + i), 0, 0));
      begin
        repeat (40) @(posedge clock);
        slot_strobe <= 1'b0;
        #1;
        chk_bits("cmd_ready full", 32'h0, {31'h0, cmd_ready});
      end
    join
    for (int i = 0; i < 17; i++) lis_ch[2][i] = 30 + i;
    for (int k = 0; k < 200 && host_model_inst.n_done < d0 + 17; k++) @(negedge clock);
    chk_bits("fill done count", 32'(d0 + 17), 32'(host_model_inst.n_done));
    $display("test fifo fill done");
    send(mk(0, 0, 0, 0, 0, 7'h00, 1, 32'hfffefffe));
    send(mk(0, 0, 1, 0, 0, 7'h1e, 0, 32'h00fffffe));
    send(mk(0, 0, 2, 0, 0, 7'h64, 1, 32'hfffefffe));
    send(mk(0, 0, 0, 0, 0, 7'h10, 1, 32'h0000fffe));
    send(mk(0, 1, 3, 0, 0, 7'h00, 1, 32'hfffefffe));
    send(mk(3, 0, 3, 0, 0, 7'h00, 0, 32'h0));
    chk_bits("drive_locked", 32'h7, {28'h0, drive_locked});
    $display("test drives done");
    for (int i = 0; i < 12; i++) begin
      send(mk(1, 0, 3, 0, 5'($urandom_range(31)), 7'($urandom_range(52)), 0, 0));
    end
    send(mk(1, 0, 3, 0, 5'd9, 7'd5, 0, 0));
    send(mk(1, 0, 0, 0, 5'd9, 7'd40, 0, 0));
    send(mk(1, 0, 3, 0, 5'd4, 7'd1, 0, 0));
    send(mk(1, 0, 3, 0, 5'd4, 7'd2, 0, 0));
    send(mk(2, 0, 1, 2, 0, 0, 0, 32'h0000ff00));
    send(mk(1, 0, 2, 0, 5'd10, 7'd0, 0, 0));
    $display("test listens done");
    for (int f = 0; f < 3; f++) begin
      for (int s = 0; s < 32; s++) slot(s);
    end
    chk_bits("host hangs", 32'h0, 32'(host_model_inst.hangs));
    $display("test frames done");
    results();
  end
endmodule : timeslot_cross_connect_bench
